/* rtl/power_monitor_result_regs.sv */
// Purpose: Mode control, conversion sequencing, averaging and result registers of a power monitor.
// Assumes: Serial bus engine presents one word access per cycle; converter codes are valid when sampled.
// Notes:   Read data follows the pointer one cycle later.
`timescale 1ns/1ps
`include "pwr_mon_cfg.svh"

module power_monitor_result_regs #(
	parameter int unsigned CYC_PER_US = `CLK_MHZ
) (
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	input  wire pwr_mon_pkg::reg_req_t     req,
	output logic [15:0]                    rdata,
	input  wire pwr_mon_pkg::adc_sample_t  adc,
	output logic                           conv_active,
	output logic                           conv_rail,
	output logic                           range_narrow
);

	pwr_mon_pkg::core_state_t q;
	pwr_mon_pkg::core_state_t d;
	logic [2:0]  mode;
	logic        run;
	logic        trig_mode;
	logic        cont_mode;
	logic [23:0] tgt;
	logic [3:0]  avg_sh;
	logic        last_ch;
	logic        cfg_wr;
	logic        cal_wr;
	logic [25:0] acc_sh_n;
	logic [25:0] acc_bus_n;
	logic [25:0] sh_avg;

	// Reset image of the whole state.
	function automatic pwr_mon_pkg::core_state_t init_state();
		pwr_mon_pkg::core_state_t s;
		s       = '0;
		s.fsm   = pwr_mon_pkg::ST_IDLE;
		s.cfg   = `CFG_RESET;
		s.cal   = `CAL_RESET;
		s.shunt = `RESULT_RESET;
		s.bus   = `RESULT_RESET;
		s.cur   = `RESULT_RESET;
		s.pwr   = `RESULT_RESET;
		return s;
	endfunction

	// Conversion time code to clock cycles.
	function automatic logic [23:0] ct_cycles(input logic [2:0] code);
		int unsigned us;
		unique case (code)
			3'h0: us = `CT_US_0;
			3'h1: us = `CT_US_1;
			3'h2: us = `CT_US_2;
			3'h3: us = `CT_US_3;
			3'h4: us = `CT_US_4;
			3'h5: us = `CT_US_5;
			3'h6: us = `CT_US_6;
			3'h7: us = `CT_US_7;
		endcase
		return 24'(us * CYC_PER_US);
	endfunction

	// Averaging code to shift; sample counts are all powers of two.
	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		unique case (code)
			3'h0: return 4'h0;
			3'h1: return 4'h2;
			3'h2: return 4'h4;
			3'h3: return 4'h6;
			3'h4: return 4'h7;
			3'h5: return 4'h8;
			3'h6: return 4'h9;
			3'h7: return 4'ha;
		endcase
	endfunction

	// Current is the signed shunt reading scaled by calibration; the shift fixes its weight.
	function automatic logic [15:0] calc_current(input logic [15:0] sh, input logic [14:0] cal);
		logic signed [31:0] prod;
		prod = $signed(sh) * $signed({1'b0, cal});
		return prod[`CURRENT_SHIFT +: 16];
	endfunction

	// Power uses the magnitude of current, so the result is never negative.
	function automatic logic [15:0] calc_power(input logic [15:0] cur, input logic [15:0] bus);
		logic [15:0] mag;
		logic [31:0] prod;
		mag  = cur[15] ? 16'(-cur) : cur;
		prod = mag * bus;
		return prod[`POWER_SHIFT +: 16];
	endfunction

	// Mode decoding; the two shutdown codes both leave the low pair zero.
	always_comb begin
		mode      = q.cfg[`CFG_MODE_LSB +: 3];
		trig_mode = !mode[2] && (mode[1:0] != 2'h0);
		cont_mode = mode[2] && (mode[1:0] != 2'h0);
		run       = cont_mode || (trig_mode && q.armed);
		tgt       = ct_cycles(q.ch ? q.cfg[`CFG_RAIL_CT_LSB +: 3] : q.cfg[`CFG_SENSE_CT_LSB +: 3]);
		avg_sh    = avg_shift(q.cfg[`CFG_AVG_LSB +: 3]);
		last_ch   = q.ch || !mode[1];
		cfg_wr    = req.wr && (req.addr == `OFS_CONFIG);
		cal_wr    = req.wr && (req.addr == `OFS_SHUNT_CAL);
	end

	// Next state: read mux, conversion sequencer, averaging, then host writes which take priority.
	always_comb begin
		d         = q;
		d.upd     = 1'b0;
		acc_sh_n  = q.acc_sh;
		acc_bus_n = q.acc_bus;
		sh_avg    = 26'h0;
		unique case (req.addr)
			`OFS_CONFIG:         d.rdata = q.cfg;
			`OFS_SHUNT_RESULT:   d.rdata = q.shunt;
			`OFS_BUS_RESULT:     d.rdata = q.bus;
			`OFS_POWER_RESULT:   d.rdata = q.pwr;
			`OFS_CURRENT_RESULT: d.rdata = q.cur;
			`OFS_SHUNT_CAL:      d.rdata = {1'b0, q.cal};
			default:             d.rdata = 16'h0000;
		endcase
		unique case (q.fsm)
			pwr_mon_pkg::ST_IDLE: begin
				if (run) begin
					d.fsm = pwr_mon_pkg::ST_CONV;
					d.cnt = 24'h0;
					d.ch  = !mode[0];
				end
			end
			pwr_mon_pkg::ST_CONV: begin
				if (q.cnt >= tgt - 24'h1) begin
					// Front end code is taken as is: one shunt count is one 2.5 uV step.
					if (q.ch) begin
						acc_bus_n = q.acc_bus + {10'h0, adc.rail_code};
					end else begin
						acc_sh_n = q.acc_sh + {{10{adc.shunt_code[15]}}, adc.shunt_code};
					end
					d.acc_sh  = acc_sh_n;
					d.acc_bus = acc_bus_n;
					d.cnt     = 24'h0;
					d.ch      = last_ch ? !mode[0] : 1'b1;
					if (last_ch) begin
						d.nsamp = q.nsamp + 11'h1;
						if (q.nsamp == (11'h1 << avg_sh) - 11'h1) begin
							// Averaged results land together, only once the count is reached.
							d.upd     = 1'b1;
							d.nsamp   = 11'h0;
							d.acc_sh  = 26'h0;
							d.acc_bus = 26'h0;
							if (mode[0]) begin
								sh_avg  = 26'($signed(acc_sh_n) >>> avg_sh);
								d.shunt = sh_avg[15:0];
							end
							if (mode[1]) begin
								d.bus = {1'b0, 15'(acc_bus_n >> avg_sh)};
							end
							d.cur = calc_current(d.shunt, q.cal);
							d.pwr = calc_power(d.cur, d.bus);
							if (trig_mode) begin
								d.armed = 1'b0;
								d.fsm   = pwr_mon_pkg::ST_IDLE;
							end
						end
					end
				end else begin
					d.cnt = q.cnt + 24'h1;
				end
				if (!run) begin
					d.fsm = pwr_mon_pkg::ST_IDLE;
				end
			end
		endcase
		// A configuration write restarts the sequence; writes to result offsets fall through unused.
		if (cfg_wr) begin
			if (req.wdata[`CFG_RST_BIT]) begin
				d = init_state();
			end else begin
				d.cfg     = {1'b0, `CFG_RSVD_VALUE, req.wdata[`CFG_RANGE_BIT:0]};
				d.fsm     = pwr_mon_pkg::ST_IDLE;
				d.cnt     = 24'h0;
				d.nsamp   = 11'h0;
				d.acc_sh  = 26'h0;
				d.acc_bus = 26'h0;
				d.armed   = !req.wdata[2] && (req.wdata[1:0] != 2'h0);
			end
		end
		if (cal_wr) begin
			d.cal = req.wdata[14:0];
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			q <= init_state();
		end else begin
			q <= d;
		end
	end

	assign rdata        = q.rdata;
	assign conv_active  = (q.fsm == pwr_mon_pkg::ST_CONV);
	assign conv_rail    = q.ch;
	assign range_narrow = q.cfg[`CFG_RANGE_BIT];

	// Checks on reset values, register access, mode handling and the derived results.
	a_reset_defaults: assert property (@(posedge clk_sys)
		srst |=> (q.cfg == `CFG_RESET) && (q.shunt == `RESULT_RESET) && (q.cal == `CAL_RESET))
		else $error("defaults wrong after reset");
	a_bus_msb_zero: assert property (@(posedge clk_sys) disable iff (srst)
		q.bus[15] == 1'b0)
		else $error("bus result bit 15 set");
	a_cal_rsvd_zero: assert property (@(posedge clk_sys) disable iff (srst)
		$past(req.addr) == `OFS_SHUNT_CAL |-> rdata[15] == 1'b0)
		else $error("calibration bit 15 read as one");
	a_cal_write_takes: assert property (@(posedge clk_sys) disable iff (srst)
		req.wr && req.addr == `OFS_SHUNT_CAL |=> q.cal == $past(req.wdata[14:0]))
		else $error("calibration write lost");
	a_results_read_only: assert property (@(posedge clk_sys) disable iff (srst)
		!q.upd && !(cfg_wr && req.wdata[15]) ##0 !d.upd
		|=> $stable(q.shunt) && $stable(q.bus) && $stable(q.cur) && $stable(q.pwr))
		else $error("result changed without update");
	a_shutdown_idle: assert property (@(posedge clk_sys) disable iff (srst)
		q.cfg[1:0] == 2'h0 && !cfg_wr ##1 q.cfg[1:0] == 2'h0 |-> !conv_active)
		else $error("converting in shutdown");
	a_single_stops: assert property (@(posedge clk_sys) disable iff (srst)
		q.upd && !q.cfg[2] && !$past(cfg_wr) |-> !q.armed && !conv_active)
		else $error("single shot kept running");
	a_current_calc: assert property (@(posedge clk_sys) disable iff (srst)
		q.upd |-> q.cur == calc_current(q.shunt, $past(q.cal)))
		else $error("current not shunt times calibration");
	a_power_calc: assert property (@(posedge clk_sys) disable iff (srst)
		q.upd |-> q.pwr == calc_power(q.cur, q.bus))
		else $error("power not current times bus");
	a_conv_time: assert property (@(posedge clk_sys) disable iff (srst)
		conv_active && q.cnt == 24'h0 && !cfg_wr |=> conv_active || q.upd)
		else $error("conversion ended at once");

endmodule

/* rtl/pwr_mon_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the power monitor result block.
// Assumes: One 200 MHz system clock; register words are 16 bits wide.
// Notes:   Definitions only; include by bare name.
`ifndef PWR_MON_CFG_SVH
`define PWR_MON_CFG_SVH

// Register pointer values.
`define OFS_CONFIG        8'h00
`define OFS_SHUNT_RESULT  8'h01
`define OFS_BUS_RESULT    8'h02
`define OFS_POWER_RESULT  8'h03
`define OFS_CURRENT_RESULT 8'h04
`define OFS_SHUNT_CAL     8'h05

// Configuration word fields, given by their low bit.
`define CFG_MODE_LSB      0
`define CFG_SENSE_CT_LSB  3
`define CFG_RAIL_CT_LSB   6
`define CFG_AVG_LSB       9
`define CFG_RANGE_BIT     12
`define CFG_RSVD_LSB      13
`define CFG_RST_BIT       15

// Reset and fixed values.
`define CFG_RESET         16'h4127
`define CFG_RSVD_VALUE    2'h2
`define RESULT_RESET      16'h0000
`define CAL_RESET         15'h0000

// Fixed point scaling of the derived results.
`define CURRENT_SHIFT     11
`define POWER_SHIFT       15

// Clock rate and conversion times in microseconds.
`define CLK_MHZ           200
`define CT_US_0           140
`define CT_US_1           204
`define CT_US_2           332
`define CT_US_3           588
`define CT_US_4           1100
`define CT_US_5           2116
`define CT_US_6           4156
`define CT_US_7           8244

`endif

/* rtl/pwr_mon_pkg.sv */
// Purpose: Types shared by the power monitor result block and its users.
// Assumes: Constants come from pwr_mon_cfg.svh.
// Notes:   Whole block state is one packed struct.
package pwr_mon_pkg;

	// Conversion sequencer states.
	typedef enum logic [0:0] {ST_IDLE, ST_CONV} seq_state_t;

	// One register access from the serial bus engine.
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Codes offered by the converter front end.
	typedef struct packed {
		logic [15:0] shunt_code;
		logic [15:0] rail_code;
	} adc_sample_t;

	// Complete block state.
	typedef struct packed {
		seq_state_t  fsm;
		logic [15:0] cfg;
		logic [14:0] cal;
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] cur;
		logic [15:0] pwr;
		logic [23:0] cnt;
		logic [10:0] nsamp;
		logic [25:0] acc_sh;
		logic [25:0] acc_bus;
		logic        armed;
		logic        ch;
		logic        upd;
		logic [15:0] rdata;
	} core_state_t;

endpackage

/* test/adc_front_model.sv */
// Purpose: Converter front end seen by the result block; offers shunt and rail codes.
// Assumes: Codes are only meaningful while a conversion is timed.
// Notes:   Outside conversions the codes are inverted so a stale sample shows up.
`timescale 1ns/1ps

module adc_front_model (
	input  wire logic                     clk_sys,
	input  wire logic                     conv_active,
	input  wire logic [15:0]              shunt_set,
	input  wire logic [15:0]              rail_set,
	output pwr_mon_pkg::adc_sample_t      adc
);
	// Real converters give no valid code between conversions, so none is shown here either.
	always_ff @(posedge clk_sys) begin
		adc.shunt_code <= conv_active ? shunt_set : ~shunt_set;
		adc.rail_code  <= conv_active ? rail_set : ~rail_set;
	end
endmodule

/* test/tb.sv */
// Purpose: Self-checking bench of the power monitor result block.
// Assumes: CYC_PER_US is 1, so conversion times are 140..8244 cycles.
// Notes:   Reads queue their expected word; a watcher compares when the word appears.
`timescale 1ns/1ps
`include "pwr_mon_cfg.svh"

module tb;
	logic                      clk_sys = 1'b0;
	logic                      srst    = 1'b1;
	pwr_mon_pkg::reg_req_t     req     = '0;
	pwr_mon_pkg::adc_sample_t  adc;
	logic [15:0]               rdata;
	logic                      conv_active;
	logic                      conv_rail;
	logic                      range_narrow;
	logic [15:0]               sh_set  = 16'h0000;
	logic [15:0]               rl_set  = 16'h0000;
	logic [15:0]               q[$];
	logic                      pend    = 1'b0;
	logic                      chk     = 1'b0;
	logic [31:0]               seed    = 32'ha9e8;
	logic [15:0]               e;
	int                        fails   = 0;
	int                        n_checks = 0;
	int                        cyc     = 0;

	always #2.5 clk_sys = ~clk_sys;

	power_monitor_result_regs #(.CYC_PER_US(1)) power_monitor_result_regs_i (.clk_sys(clk_sys), .srst(srst),
		.req(req), .rdata(rdata), .adc(adc), .conv_active(conv_active), .conv_rail(conv_rail),
		.range_narrow(range_narrow));
	adc_front_model adc_front_model_i (.clk_sys(clk_sys), .conv_active(conv_active), .shunt_set(sh_set),
		.rail_set(rl_set), .adc(adc));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Compare one settled value and count it.
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The word appears one edge after its address, so the watcher samples half a cycle later.
	always @(posedge clk_sys) chk <= pend;
	always @(negedge clk_sys) begin
		if (chk && q.size() > 0) begin
			e = q.pop_front();
			cmp(rdata, e);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		req <= '{wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_sys);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk_sys);
		req.addr <= a;
		pend <= 1'b1;
		q.push_back(exp);
		@(negedge clk_sys);
		pend <= 1'b0;
		@(negedge clk_sys);
	endtask

	// Bounded wait for the conversion pass to finish, plus the result update edge.
	task automatic wait_done();
		int n;
		repeat (3) @(negedge clk_sys);
		for (n = 0; n < 3000 && conv_active; n++) @(negedge clk_sys);
		repeat (3) @(negedge clk_sys);
	endtask

	// Counts the cycles of one single-shot shunt pass; the bound keeps a stuck sequencer from hanging here.
	task automatic conv_len(input logic [15:0] cfg, input logic [15:0] exp);
		logic [15:0] n;
		n = 16'h0000;
		wr(8'h00, cfg);
		@(negedge clk_sys);
		while (conv_active && n < 16'h2400) begin
			n++;
			@(negedge clk_sys);
		end
		cmp(n, exp);
	endtask

	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask

	task automatic complete_run();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard; the whole sequence needs roughly 3800 cycles.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		repeat (20) @(negedge clk_sys);
		srst <= 1'b0;
		wr(8'h00, 16'h4000);
		rd(8'h00, 16'h4000);
		rd(8'h01, 16'h0000);
		rd(8'h04, 16'h0000);
		rd(8'h05, 16'h0000);
		rd(8'h07, 16'h0000);
		wr(8'h05, 16'hffff);
		rd(8'h05, 16'h7fff);
		wr(8'h03, 16'h1234);
		rd(8'h03, 16'h0000);
		tdone("registers");
		wr(8'h05, 16'h0800);
		sh_set = 16'h0100;
		rl_set = 16'h0200;
		wr(8'h00, 16'h4003);
		wait_done();
		rd(8'h01, 16'h0100);
		rd(8'h02, 16'h0200);
		rd(8'h04, 16'h0100);
		rd(8'h03, 16'h0004);
		repeat (300) @(negedge clk_sys);
		cmp({15'h0000, conv_active}, 16'h0000);
		tdone("single both");
		sh_set = 16'h8300;
		wr(8'h00, 16'h4001);
		repeat (5) @(negedge clk_sys);
		cmp({14'h0000, conv_rail, conv_active}, 16'h0001);
		wait_done();
		rd(8'h01, 16'h8300);
		rd(8'h04, 16'h8300);
		rl_set = 16'hffff;
		wr(8'h00, 16'h4002);
		repeat (5) @(negedge clk_sys);
		cmp({14'h0000, conv_rail, conv_active}, 16'h0003);
		wait_done();
		rd(8'h02, 16'h7fff);
		rd(8'h01, 16'h8300);
		tdone("single channels");
		seed = xs(seed);
		sh_set = seed[15:0];
		wr(8'h00, 16'h4201);
		repeat (300) @(negedge clk_sys);
		rd(8'h01, 16'h8300);
		wait_done();
		rd(8'h01, seed[15:0]);
		rd(8'h04, seed[15:0]);
		tdone("averaging");
		conv_len(16'h4001, 16'(`CT_US_0));
		conv_len(16'h4029, 16'(`CT_US_5));
		tdone("conversion times");
		wr(8'h00, 16'h4004);
		repeat (5) @(negedge clk_sys);
		cmp({15'h0000, conv_active}, 16'h0000);
		wr(8'h00, 16'h5005);
		repeat (5) @(negedge clk_sys);
		cmp({14'h0000, range_narrow, conv_active}, 16'h0003);
		wr(8'h00, 16'h8000);
		rd(8'h00, 16'h4127);
		rd(8'h05, 16'h0000);
		rd(8'h01, 16'h0000);
		tdone("modes and reset");
		repeat (4) @(negedge clk_sys);
		complete_run();
	end
endmodule
